// ### logic/mks_pkg.sv
// Constants, state codes and line decoding shared by the key matrix scanner
// Operation
// - Eight scan lines cross eight receive lines
// - Scan and receive lines on separate ports
// - Waiting: scan lines low, receive lines high
// - Receive lines ANDed into active-low wake request
// - Single pressed key becomes a key code
// - Several pressed keys: discard, pulse keyReject, key code unchanged
// - Modifier pins never lock out nor wake
// - Idle in low power until key request
// - Wait about thirty milliseconds to debounce
// - Latch receive, turn lines around, read scan
// - Scan number high nibble, receive low nibble
// - Request is edge triggered, once per press
// - Clear pending flag after debounce wait
package mks_pkg;

    localparam int unsigned LINE_COUNT     = 8;
    localparam int unsigned MOD_COUNT      = 4;
    localparam int unsigned DEBOUNCE_MS    = 30;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    // Longest wait rounds down; 3,750,000 cycles at 125 MHz
    localparam int unsigned DEBOUNCE_CYC_DEF = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
    // Turnaround settling of the pull-ups after lines change direction
    localparam int unsigned SETTLE_CYC     = 2;
    // Line numbers in the key address count from one
    localparam logic [3:0]  LINE_BASE      = 4'h1;
    localparam logic [7:0]  LINES_LOW      = 8'h00;
    localparam logic [7:0]  LINES_HIGH     = 8'hFF;
    localparam logic [7:0]  CODE_RESET     = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_DEBOUNCE = 3'h1,
        ST_LATCH    = 3'h2,
        ST_SETTLE   = 3'h3,
        ST_READ     = 3'h4,
        ST_RESTORE  = 3'h5
    } mks_state_t;

    // Returns {exactly one zero, number of that zero line}
    function automatic logic [4:0] findLowLine(input logic [7:0] v);
        logic [3:0] zeros;
        logic [3:0] idx;
        zeros = 4'h0;
        idx   = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (!v[i]) begin
                zeros = zeros + 4'h1;
                idx   = 4'(i) + LINE_BASE;
            end
        end
        return {(zeros == 4'h1), idx};
    endfunction : findLowLine

endpackage : mks_pkg

// ### logic/mks_scanner.sv
// Key matrix scanner: wake request, debounce, two-key lockout and key address
`timescale 1ns/1ns
module mks_scanner
    import mks_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF,
    parameter int unsigned CNT_W        = $clog2(DEBOUNCE_CYC + 1)
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    output logic [LINE_COUNT-1:0]     scanOut,
    output logic [LINE_COUNT-1:0]     scanOe,
    input  wire logic [LINE_COUNT-1:0] scanIn,
    output logic [LINE_COUNT-1:0]     rcvOut,
    output logic [LINE_COUNT-1:0]     rcvOe,
    input  wire logic [LINE_COUNT-1:0] rcvIn,
    input  wire logic [MOD_COUNT-1:0] modIn,
    output logic                      keyIrqN,
    output logic                      keyIrqPendingFlag,
    output logic                      lowPower,
    output logic [7:0]                keyCode,
    output logic [MOD_COUNT-1:0]      keyMods,
    output logic                      keyValid,
    output logic                      keyReject
);

    mks_state_t           state;
    mks_state_t           next_state;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     next_cnt;
    logic [3:0]           rcvNum;
    logic [3:0]           next_rcvNum;
    logic [7:0]           next_scanOut;
    logic [7:0]           next_scanOe;
    logic [7:0]           next_rcvOut;
    logic [7:0]           next_rcvOe;
    logic                 next_keyIrqN;
    logic                 next_flag;
    logic                 next_lowPower;
    logic [7:0]           next_keyCode;
    logic [MOD_COUNT-1:0] next_keyMods;
    logic                 next_keyValid;
    logic                 next_keyReject;
    logic                 rcvAllHigh;
    logic                 armed;
    logic                 setEdge;
    logic                 debDone;
    logic [4:0]           rcvScan;
    logic [4:0]           scanScan;

    localparam logic [CNT_W-1:0] DEB_LAST    = CNT_W'(DEBOUNCE_CYC - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

    // Modifier pins are not in the AND, so they can never wake the block
    assign rcvAllHigh = &rcvIn;
    // Edges count only while armed; our own turnaround edges are ignored
    assign armed      = (state == ST_IDLE) || (state == ST_DEBOUNCE);
    assign setEdge    = armed && keyIrqN && !rcvAllHigh;
    assign debDone    = (state == ST_DEBOUNCE) && (cnt == DEB_LAST);
    assign rcvScan    = findLowLine(rcvIn);
    assign scanScan   = findLowLine(scanIn);

    // Next-state and output computation for the whole scanner
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_rcvNum    = rcvNum;
        next_scanOut   = scanOut;
        next_scanOe    = scanOe;
        next_rcvOut    = rcvOut;
        next_rcvOe     = rcvOe;
        next_keyCode   = keyCode;
        next_keyMods   = keyMods;
        next_keyValid  = 1'b0;
        next_keyReject = 1'b0;
        next_keyIrqN   = rcvAllHigh;
        // Set wins over any clear in the same cycle
        next_flag      = setEdge || keyIrqPendingFlag;
        unique case (state)
            ST_IDLE: begin
                if (keyIrqPendingFlag) begin
                    next_state = ST_DEBOUNCE;
                    next_cnt   = '0;
                    next_flag  = setEdge;                           // Taken on entry
                end
            end
            ST_DEBOUNCE: begin
                next_cnt = cnt + CNT_W'(1);
                if (debDone) begin
                    // Bounce edges caught during the wait are thrown away
                    next_flag  = setEdge;
                    next_state = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // Modifiers are sampled beside the matrix, never counted in it
                next_keyMods = modIn;
                next_rcvNum  = rcvScan[3:0];
                if (!rcvScan[4]) begin
                    next_keyReject = 1'b1;
                    next_state     = ST_RESTORE;
                end else begin
                    // Receive lines driven low, scan lines released to pull-ups
                    next_rcvOut = LINES_LOW;
                    next_rcvOe  = LINES_HIGH;
                    next_scanOut = LINES_HIGH;
                    next_scanOe  = LINES_LOW;
                    next_state   = ST_SETTLE;
                end
                next_cnt = '0;
            end
            ST_SETTLE: begin
                next_cnt = cnt + CNT_W'(1);
                if (cnt == SETTLE_LAST) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (scanScan[4]) begin
                    next_keyCode  = {scanScan[3:0], rcvNum};
                    next_keyValid = 1'b1;
                end else begin
                    next_keyReject = 1'b1;
                end
                next_state = ST_RESTORE;
                next_cnt   = '0;
            end
            ST_RESTORE: begin
                // Idle levels back before edges are watched again
                next_scanOut = LINES_LOW;
                next_scanOe  = LINES_HIGH;
                next_rcvOut  = LINES_HIGH;
                next_rcvOe   = LINES_LOW;
                next_cnt     = cnt + CNT_W'(1);
                if (cnt == SETTLE_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_RESTORE;
                next_cnt   = '0;
            end
        endcase
        next_lowPower = (next_state == ST_IDLE);
    end

    // Registers; receive lines rest released so the pull-ups hold them high
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state             <= ST_IDLE;
            cnt               <= '0;
            rcvNum            <= 4'h0;
            scanOut           <= LINES_LOW;
            scanOe            <= LINES_HIGH;
            rcvOut            <= LINES_HIGH;
            rcvOe             <= LINES_LOW;
            keyIrqN           <= 1'b1;
            keyIrqPendingFlag <= 1'b0;
            lowPower          <= 1'b1;
            keyCode           <= CODE_RESET;
            keyMods           <= '0;
            keyValid          <= 1'b0;
            keyReject         <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            rcvNum            <= next_rcvNum;
            scanOut           <= next_scanOut;
            scanOe            <= next_scanOe;
            rcvOut            <= next_rcvOut;
            rcvOe             <= next_rcvOe;
            keyIrqN           <= next_keyIrqN;
            keyIrqPendingFlag <= next_flag;
            lowPower          <= next_lowPower;
            keyCode           <= next_keyCode;
            keyMods           <= next_keyMods;
            keyValid          <= next_keyValid;
            keyReject         <= next_keyReject;
        end
    end

    // Checks on line levels, timing and result encoding
    a_idle_lines: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE) |-> (scanOut == LINES_LOW && scanOe == LINES_HIGH
                                && rcvOut == LINES_HIGH && rcvOe == LINES_LOW))
        else $error("Idle line levels wrong");

    a_wake_and: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(&rcvIn) |=> !keyIrqN)
        else $error("Wake request missed a low receive line");

    a_edge_once: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(keyIrqPendingFlag) |-> $past(keyIrqN) && !$past(rcvAllHigh))
        else $error("Pending flag set without a falling edge");

    a_wake_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE && keyIrqPendingFlag) |=> (state == ST_DEBOUNCE && !lowPower))
        else $error("Pending request did not end idle");

    a_debounce_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_LATCH && $past(state) == ST_DEBOUNCE) |-> $past(cnt) == DEB_LAST)
        else $error("Debounce wait ended early");

    a_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        debDone && !setEdge |=> !keyIrqPendingFlag)
        else $error("Pending flag kept after debounce");

    a_turnaround: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_READ) |-> (rcvOut == LINES_LOW && rcvOe == LINES_HIGH
                                && scanOe == LINES_LOW))
        else $error("Lines not turned around at scan read");

    a_code_nibble: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_READ && scanScan[4]) |=> keyValid
            && keyCode == {$past(scanScan[3:0]), $past(rcvNum)})
        else $error("Key address nibbles wrong");

    a_lockout: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_LATCH && !rcvScan[4]) |=> keyReject && !keyValid
            && state == ST_RESTORE)
        else $error("Multiple keys not locked out");

    a_restore_rearm: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE && $past(state) == ST_RESTORE) |-> (scanOe == LINES_HIGH
                                && rcvOe == LINES_LOW))
        else $error("Re-armed before lines restored");

    c_key_valid: cover property (@(posedge core_clk) disable iff (sys_rst) keyValid);
    c_key_reject: cover property (@(posedge core_clk) disable iff (sys_rst)
        keyReject && $past(state) == ST_READ);
    c_bounce_wait: cover property (@(posedge core_clk) disable iff (sys_rst)
        setEdge && state == ST_DEBOUNCE);

endmodule : mks_scanner

// ### verif/mks_key_matrix.sv
// Passive eight by eight switch matrix with pull-ups on every line
`timescale 1ns/1ns
module mks_key_matrix (
    input  wire logic [63:0] keys,
    input  wire logic [7:0]  scanOut,
    input  wire logic [7:0]  scanOe,
    input  wire logic [7:0]  rcvOut,
    input  wire logic [7:0]  rcvOe,
    output logic [7:0]       scanIn,
    output logic [7:0]       rcvIn
);
    // Closed key at bit s*8+r joins scan s to receive r; a driven low wins over the pull-up
    // Chains through several keys are not followed; one hop is enough for lockout cases
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            scanIn[s] = scanOe[s] ? scanOut[s] : 1'b1;
            for (int r = 0; r < 8; r++) begin
                if (keys[s*8+r] && rcvOe[r] && !rcvOut[r]) scanIn[s] = 1'b0;
            end
        end
        for (int r = 0; r < 8; r++) begin
            rcvIn[r] = rcvOe[r] ? rcvOut[r] : 1'b1;
            for (int s = 0; s < 8; s++) begin
                if (keys[s*8+r] && scanOe[s] && !scanOut[s]) rcvIn[r] = 1'b0;
            end
        end
    end
endmodule : mks_key_matrix

// ### verif/tb_matrix_keypad_scanner.sv
// Self-checking bench for the key matrix scanner against a switch matrix model
`timescale 1ns/1ns
module tb_matrix_keypad_scanner;
    import mks_pkg::*;
    localparam int unsigned DEB = 20;
    // Edges from the bounce re-press to the result pulse: full service, early lockout
    localparam int unsigned SVC = DEB + SETTLE_CYC + 2;
    localparam int unsigned LAT = DEB + 1;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [63:0] keys     = 64'h0;
    logic [3:0]  modIn    = 4'h0;
    logic [7:0]  scanOut, scanOe, scanIn, rcvOut, rcvOe, rcvIn, keyCode;
    logic [3:0]  keyMods;
    logic        keyIrqN, keyIrqPendingFlag, lowPower, keyValid, keyReject;
    logic [12:0] expQ[$];
    logic [12:0] got;
    int          numErrors  = 0;
    int          numChecks  = 0;
    logic [7:0]  lastCode   = CODE_RESET;
    int          s, r;
    logic [3:0]  m;

    always #4 core_clk = ~core_clk;

    mks_scanner #(.DEBOUNCE_CYC(DEB)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .scanOut(scanOut), .scanOe(scanOe), .scanIn(scanIn), .rcvOut(rcvOut),
        .rcvOe(rcvOe), .rcvIn(rcvIn), .modIn(modIn), .keyIrqN(keyIrqN),
        .keyIrqPendingFlag(keyIrqPendingFlag), .lowPower(lowPower), .keyCode(keyCode),
        .keyMods(keyMods), .keyValid(keyValid), .keyReject(keyReject));
    mks_key_matrix PM (.keys(keys), .scanOut(scanOut), .scanOe(scanOe), .rcvOut(rcvOut),
        .rcvOe(rcvOe), .scanIn(scanIn), .rcvIn(rcvIn));

    task automatic check(input logic ok, input string msg);
        numChecks++;
        if (ok !== 1'b1) begin
            numErrors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic wrapUp();
        if (numErrors == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrapUp

    // Idle line levels, also after every service
    task automatic check_idle();
        check(scanOe === 8'hFF && scanOut === 8'h00, "scan lines not low");
        check(rcvOe === 8'h00 && rcvIn === 8'hFF, "receive lines not high");
        check(rcvOut === 8'hFF, "receive drive not high");
        check(lowPower === 1'b1, "not idle");
    endtask : check_idle

    // Press with one bounce during debounce, hold well past the result, then release
    task automatic press(input logic [63:0] k, input logic [3:0] md, input logic want,
                         input logic [12:0] exp, input int cyc);
        int n;
        if (want) expQ.push_back(exp);
        @(posedge core_clk);
        keys  <= k;
        modIn <= md;
        repeat (2) @(posedge core_clk);
        if (want) check(keyIrqN === 1'b0, "no wake request");
        if (!want) check(keyIrqN === 1'b1, "modifier woke");
        if (want) check(keyIrqPendingFlag === 1'b1, "no pending request");
        if (!want) check(keyIrqPendingFlag === 1'b0, "modifier set request");
        keys <= 64'h0;
        @(posedge core_clk);
        keys <= k;
        n = 0;
        while (want && keyValid !== 1'b1 && keyReject !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        check(n < 200, "no result");
        // The bounce must not restart the wait, and the wait must not be cut short
        check(n == cyc, "result timing");
        // A held key must not give a second result; the monitor flags any extra
        repeat (40) @(posedge core_clk);
        keys <= 64'h0;
        repeat (12) @(posedge core_clk);
        check_idle();
    endtask : press

    // Monitor: every result must match the oldest expectation
    always @(posedge core_clk) begin
        if (sys_rst === 1'b0 && (keyValid === 1'b1 || keyReject === 1'b1)) begin
            if (expQ.size() == 0) begin
                check(1'b0, "unexpected result");
            end else begin
                got = expQ.pop_front();
                check(keyValid === got[12] && keyReject === !got[12], "result kind");
                if (got[12]) check(keyCode === got[7:0], "key code");
                if (got[12]) check(keyMods === got[11:8], "modifiers");
                if (!got[12]) check(keyCode === lastCode, "code changed on lockout");
                if (got[12]) lastCode = got[7:0];
                check(lowPower === 1'b0, "idle during service");
            end
        end
    end

    initial begin
        void'($urandom(86));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check_idle();
        // Corner keys first, then random single keys with random modifiers
        for (int i = 0; i < 10; i++) begin
            s = (i == 0) ? 0 : (i == 1) ? 7 : int'($urandom % 8);
            r = (i == 0) ? 0 : (i == 1) ? 7 : int'($urandom % 8);
            m = 4'($urandom);
            press(64'h1 << (s*8+r), m, 1'b1, {1'b1, m, 4'(s) + 4'h1, 4'(r) + 4'h1}, SVC);
        end
        press(64'h1 << 10 | 64'h1 << 13, 4'h0, 1'b1, 13'h0000, LAT);
        press(64'h1 << 10 | 64'h1 << 34, 4'h0, 1'b1, 13'h0000, SVC);
        press(64'h0, 4'hF, 1'b0, 13'h0000, 0);
        check(expQ.size() == 0, "missing results");
        wrapUp();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(8 * 20000);
        numErrors++;
        wrapUp();
    end
endmodule : tb_matrix_keypad_scanner
